// File: src/sarseq_map.svh
// Register offsets, field positions, reset values and timing counts of the
// conversion sequencer. Included by the package user files; definitions only.
// What this block does
// - A start enables the trial clock and clears the approximation register first.
// - A running conversion always completes; nothing aborts or restarts it.
// - While converting, the result is withheld from the outputs.
// - The register, stepped by the trial clock, raises end-of-convert after its last trial.
// - End-of-convert stops the trial clock and drops the busy status output.
// - After completion a read command may place the result on the outputs.
// - Trials go one bit at a time from the top bit down to the bottom bit in a full conversion, down to bit 4 in a short one.
// - Each trial bit is set and kept if the comparator says below, else cleared.
// - After the trials the register holds the 12-bit binary result in a full conversion, and the top 8 result bits over zeros in a short one.
// - The code is straight binary; a full conversion gives all zeros at range bottom and all ones at top, a short one hex 008 and hex FF8.
// - Busy is high only while converting, and data pins float meanwhile.
// - A start while busy neither resets the sequencer nor begins a conversion.
// - The length select is latched at start; high gives 8 trials, low gives 12.
// - After a short conversion the three lowest bits read zero and bit 3 reads one.
`ifndef SARSEQ_MAP_SVH
`define SARSEQ_MAP_SVH

// ============================================================
// Register offsets (byte addresses)
`define SARSEQ_OFF_CTRL 8'h00
`define SARSEQ_OFF_STATUS 8'h04
`define SARSEQ_OFF_RESULT 8'h08
`define SARSEQ_OFF_INT_STAT 8'h0C
`define SARSEQ_OFF_INT_MASK 8'h10

// ============================================================
// Field positions
`define SARSEQ_CTRL_START 0
`define SARSEQ_CTRL_SHORT 1
`define SARSEQ_ST_BUSY 0
`define SARSEQ_ST_VALID 1
`define SARSEQ_ST_SHORT 2
`define SARSEQ_INT_EOC 0
`define SARSEQ_INT_IGNORED 1

// ============================================================
// Reset values
`define SARSEQ_RST_MASK 2'h0
`define SARSEQ_RST_SHORT 1'b0

// ============================================================
// Timing: full conversion time, clock period and trial count, per-trial cycle count derived
`define SARSEQ_CONV_US 25
`define SARSEQ_CLK_NS 25
`define SARSEQ_FULL_TRIALS 12
`define SARSEQ_TRIAL_CYC ((`SARSEQ_CONV_US * 1000 / `SARSEQ_CLK_NS) / `SARSEQ_FULL_TRIALS)

`endif

// File: src/sarseq_pkg.sv
// Types shared by the conversion sequencer modules.
// Assumes nothing of its surroundings.
package sarseq_pkg;
  typedef enum logic {SARSEQ_IDLE, SARSEQ_RUN} sarseq_state_e;
  typedef logic [1:0] sarseq_irq_t;
endpackage

// File: src/sarseq_clk_if.sv
// Trial clock control between sequencer and trial clock generator.
// Assumes both ends run on the same bus clock.
`timescale 1ns/1ps
interface sarseq_clk_if;
  logic run;
  logic tick;
  modport gen (input run, output tick);
  modport seq (output run, input tick);
endinterface

// File: src/sarseq_sync.sv
// Two-stage synchroniser for asynchronous pins, one stage pair per bit.
// Assumes the inputs may change at any time relative to pclk.
`timescale 1ns/1ps
module sarseq_sync #(
  parameter int W = 1
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  for (genvar i = 0; i < W; i++) begin : g_bit
    logic meta_q;
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        meta_q <= 1'b0;
        q[i] <= 1'b0;
      end else if (ce) begin
        meta_q <= d[i];
        q[i] <= meta_q;
      end
    end
  end
endmodule // sarseq_sync

// File: src/sarseq_clkgen.sv
// Trial clock generator: a divider that only counts while enabled.
// Assumes the sequencer holds run high for the whole conversion.
`timescale 1ns/1ps
`include "sarseq_map.svh"
module sarseq_clkgen
  import sarseq_pkg::*;
#(
  parameter int TRIAL_CYC = `SARSEQ_TRIAL_CYC
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  sarseq_clk_if.gen clk_ctl
);
  localparam int CW = (TRIAL_CYC > 1) ? $clog2(TRIAL_CYC) : 1;
  logic [CW-1:0] cnt_q;

  // Stopping the divider also restarts its phase, so every trial is full length.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q <= '0;
    end else if (ce) begin
      if (!clk_ctl.run || cnt_q == CW'(TRIAL_CYC - 1)) begin
        cnt_q <= '0;
      end else begin
        cnt_q <= cnt_q + CW'(1);
      end
    end
  end

  assign clk_ctl.tick = clk_ctl.run && (cnt_q == CW'(TRIAL_CYC - 1));
endmodule // sarseq_clkgen

// File: src/sarseq_top.sv
// Successive-approximation conversion sequencer with an APB register file.
// Assumes an analog comparator and trial DAC outside, and asynchronous pins
// for start, length select and read command.
//
// Added by the designer: the placing of the registers and the APB slave port.
`timescale 1ns/1ps
`include "sarseq_map.svh"
module sarseq_top
  import sarseq_pkg::*;
#(
  parameter int RES_W = 12,
  parameter int SHORT_TRIALS = 8,
  parameter int TRIAL_CYC = `SARSEQ_TRIAL_CYC
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic start_pin,
  input wire logic length_byte_select,
  input wire logic read_cmd_pin,
  input wire logic comp_below,
  output logic [RES_W-1:0] capacitor_trial_dac,
  output logic conversion_busy_status,
  output logic [RES_W-1:0] data_out,
  output logic data_oe,
  output logic irq
);

  // ============================================================
  // Pin synchronisers

  localparam int IW = $clog2(RES_W);
  localparam int LAST_SHORT = RES_W - SHORT_TRIALS;

  logic start_s;
  logic len_s;
  logic read_s;
  logic comp_s;
  logic start_prev_q;

  sarseq_sync #(
    .W(4)
  ) u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .ce(ce),
    .d({start_pin, length_byte_select, read_cmd_pin, comp_below}),
    .q({start_s, len_s, read_s, comp_s})
  );

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      start_prev_q <= 1'b0;
    end else if (ce) begin
      start_prev_q <= start_s;
    end
  end

  // ============================================================
  // Trial clock

  sarseq_clk_if clk_ctl ();

  sarseq_clkgen #(
    .TRIAL_CYC(TRIAL_CYC)
  ) u_clkgen (
    .pclk(pclk),
    .presetn(presetn),
    .ce(ce),
    .clk_ctl(clk_ctl)
  );

  // ============================================================
  // APB decode

  logic setup_rd;
  logic acc;
  logic wr_acc;
  logic rd_acc;
  logic hit;
  logic [31:0] rd_mux;

  assign setup_rd = psel && !penable && !pwrite;
  assign acc = psel && penable;
  assign wr_acc = acc && pwrite;
  assign rd_acc = acc && !pwrite;

  always_comb begin
    unique case (paddr)
      `SARSEQ_OFF_CTRL,
      `SARSEQ_OFF_STATUS,
      `SARSEQ_OFF_RESULT,
      `SARSEQ_OFF_INT_STAT,
      `SARSEQ_OFF_INT_MASK: hit = 1'b1;
      default: hit = 1'b0;
    endcase
  end

  // Zero-wait slave: every access completes in its first access cycle.
  assign pready = 1'b1;
  assign pslverr = acc && !hit;

  // ============================================================
  // Start arbitration

  sarseq_state_e state_q;
  logic sw_start;
  logic pin_start;
  logic start_req;
  logic start_go;
  logic start_lost;
  logic short_cfg_q;
  logic short_q;

  assign sw_start = wr_acc && paddr == `SARSEQ_OFF_CTRL && pwdata[`SARSEQ_CTRL_START];
  assign pin_start = start_s && !start_prev_q;
  assign start_req = sw_start || pin_start;
  assign start_go = start_req && state_q == SARSEQ_IDLE;
  // A start during a conversion is only recorded, never acted on.
  assign start_lost = start_req && state_q == SARSEQ_RUN;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      short_cfg_q <= `SARSEQ_RST_SHORT;
    end else if (ce && wr_acc && paddr == `SARSEQ_OFF_CTRL) begin
      short_cfg_q <= pwdata[`SARSEQ_CTRL_SHORT];
    end
  end

  // Software and pin requests share one length latch; the pin wins if both.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      short_q <= `SARSEQ_RST_SHORT;
    end else if (ce && start_go) begin
      short_q <= pin_start ? len_s : short_cfg_q;
    end
  end

  // ============================================================
  // Approximation sequencer

  logic [RES_W-1:0] sar_q;
  logic [IW-1:0] idx_q;
  logic [IW-1:0] last_idx;
  logic last_trial;
  logic eoc;

  assign last_idx = short_q ? IW'(LAST_SHORT) : '0;
  assign last_trial = idx_q == last_idx;
  assign eoc = state_q == SARSEQ_RUN && clk_ctl.tick && last_trial;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= SARSEQ_IDLE;
    end else if (ce) begin
      unique case (state_q)
        SARSEQ_IDLE: begin
          if (start_go) begin
            state_q <= SARSEQ_RUN;
          end
        end
        SARSEQ_RUN: begin
          // Only the last trial leaves this state; no input aborts it.
          if (eoc) begin
            state_q <= SARSEQ_IDLE;
          end
        end
      endcase
    end
  end

  assign clk_ctl.run = state_q == SARSEQ_RUN;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      idx_q <= '0;
    end else if (ce) begin
      if (start_go) begin
        idx_q <= IW'(RES_W - 1);
      end else if (clk_ctl.tick && !last_trial) begin
        idx_q <= idx_q - IW'(1);
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sar_q <= '0;
    end else if (ce) begin
      if (start_go) begin
        sar_q <= '0;
      end else if (clk_ctl.tick) begin
        sar_q[idx_q] <= comp_s;
      end
    end
  end

  // The trial bit is presented for the whole trial period so the comparator
  // and its synchroniser have settled long before the sampling tick.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      capacitor_trial_dac <= '0;
    end else if (ce) begin
      if (start_go) begin
        capacitor_trial_dac <= {1'b1, {(RES_W - 1){1'b0}}};
      end else if (clk_ctl.tick) begin
        capacitor_trial_dac <= sar_q;
        capacitor_trial_dac[idx_q] <= comp_s;
        if (!last_trial) begin
          capacitor_trial_dac[idx_q - IW'(1)] <= 1'b1;
        end
      end
    end
  end

  // ============================================================
  // Result and status

  logic [RES_W-1:0] final_code;
  logic valid_q;

  // Straight binary: the register bits are the code with no offset applied.
  always_comb begin
    final_code = sar_q;
    final_code[idx_q] = comp_s;
    if (short_q) begin
      final_code[LAST_SHORT-1:0] = {1'b1, {(LAST_SHORT - 1){1'b0}}};
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      data_out <= '0;
    end else if (ce && eoc) begin
      data_out <= final_code;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      valid_q <= 1'b0;
    end else if (ce) begin
      if (start_go) begin
        valid_q <= 1'b0;
      end else if (eoc) begin
        valid_q <= 1'b1;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      conversion_busy_status <= 1'b0;
    end else if (ce) begin
      if (start_go) begin
        conversion_busy_status <= 1'b1;
      end else if (eoc) begin
        conversion_busy_status <= 1'b0;
      end
    end
  end

  // Pins float while busy, and also until the first result exists.
  assign data_oe = read_s && valid_q && !conversion_busy_status;

  // ============================================================
  // Interrupts

  sarseq_irq_t int_stat_q;
  sarseq_irq_t int_mask_q;
  sarseq_irq_t int_set;
  sarseq_irq_t int_clr;

  assign int_set[`SARSEQ_INT_EOC] = eoc;
  assign int_set[`SARSEQ_INT_IGNORED] = start_lost;
  // Only bits software actually saw at setup are cleared, so an event
  // arriving between setup and access survives the read.
  assign int_clr = (rd_acc && paddr == `SARSEQ_OFF_INT_STAT) ?
                   prdata[1:0] : '0;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      int_stat_q <= '0;
    end else if (ce) begin
      int_stat_q <= (int_stat_q & ~int_clr) | int_set;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      int_mask_q <= `SARSEQ_RST_MASK;
    end else if (ce && wr_acc && paddr == `SARSEQ_OFF_INT_MASK) begin
      int_mask_q <= pwdata[1:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq <= 1'b0;
    end else if (ce) begin
      irq <= |(((int_stat_q & ~int_clr) | int_set) & int_mask_q);
    end
  end

  // ============================================================
  // Read data

  always_comb begin
    rd_mux = '0;
    unique case (paddr)
      `SARSEQ_OFF_CTRL: begin
        rd_mux[`SARSEQ_CTRL_SHORT] = short_cfg_q;
      end
      `SARSEQ_OFF_STATUS: begin
        rd_mux[`SARSEQ_ST_BUSY] = conversion_busy_status;
        rd_mux[`SARSEQ_ST_VALID] = valid_q;
        rd_mux[`SARSEQ_ST_SHORT] = short_q;
      end
      `SARSEQ_OFF_RESULT: begin
        if (!conversion_busy_status) begin
          rd_mux[RES_W-1:0] = data_out;
        end
      end
      `SARSEQ_OFF_INT_STAT: begin
        rd_mux[1:0] = int_stat_q;
      end
      `SARSEQ_OFF_INT_MASK: begin
        rd_mux[1:0] = int_mask_q;
      end
      default: begin
        rd_mux = '0;
      end
    endcase
  end

  // Read data is captured in the setup cycle and held through the access.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= '0;
    end else if (ce && setup_rd) begin
      prdata <= rd_mux;
    end
  end

endmodule // sarseq_top

// File: bench/sarseq_properties.sv
// Concurrent checks on the conversion sequencer top ports.
// Assumes one clock pclk and the asynchronous active-low reset presetn.
`timescale 1ns/1ps
module sarseq_props #(
  parameter int RES_W = 12,
  parameter int SHORT_TRIALS = 8,
  parameter int TRIAL_CYC = 6
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic [7:0] paddr,
  input wire logic pslverr,
  input wire logic [RES_W-1:0] capacitor_trial_dac,
  input wire logic conversion_busy_status,
  input wire logic [RES_W-1:0] data_out,
  input wire logic data_oe
);
  // ====================================================
  // Helper logic
  // Busy stands from the start edge to the last tick, one trial period per bit.
  localparam int FULL_CYC = RES_W * TRIAL_CYC;
  localparam int SHORT_CYC = SHORT_TRIALS * TRIAL_CYC;
  logic [15:0] busy_cnt_q;
  logic [RES_W-1:0] low_bit;
  assign low_bit = capacitor_trial_dac & (~capacitor_trial_dac + 1'b1);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      busy_cnt_q <= '0;
    end else if (conversion_busy_status) begin
      busy_cnt_q <= busy_cnt_q + 16'h1;
    end else begin
      busy_cnt_q <= '0;
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ====================================================
  // Assertions
  chk_start_msb: assert property (
    $rose(conversion_busy_status) |-> capacitor_trial_dac == {1'b1, {(RES_W-1){1'b0}}})
    else $error("trial code at start is not the top bit alone");
  chk_hidden_busy: assert property (
    conversion_busy_status |-> !data_oe)
    else $error("data driven while converting");
  chk_trial_hold: assert property (
    conversion_busy_status && $changed(capacitor_trial_dac)
      |=> (!conversion_busy_status || $stable(capacitor_trial_dac)) [*4])
    else $error("trial code changed within one trial period");
  chk_top_down: assert property (
    $past(conversion_busy_status) && conversion_busy_status && $changed(capacitor_trial_dac)
      |-> ((capacitor_trial_dac ^ $past(capacitor_trial_dac))
           & ~($past(low_bit) | ($past(low_bit) >> 1))) == '0)
    else $error("a bit other than the trial bit or the next lower changed");
  chk_conv_length: assert property (
    $fell(conversion_busy_status) |-> busy_cnt_q == FULL_CYC || busy_cnt_q == SHORT_CYC)
    else $error("conversion length is neither full nor short");
  chk_busy_bounded: assert property (
    busy_cnt_q <= FULL_CYC)
    else $error("busy longer than a full conversion");
  chk_short_tail: assert property (
    $fell(conversion_busy_status) && busy_cnt_q == SHORT_CYC |-> data_out[3:0] == 4'h8)
    else $error("short result tail is not 1000");
  chk_unmapped_err: assert property (
    psel && penable && pslverr |-> !(paddr inside {8'h00, 8'h04, 8'h08, 8'h0C, 8'h10}))
    else $error("error response on a mapped address");
  cov_full: cover property ($fell(conversion_busy_status) && busy_cnt_q == FULL_CYC);
  cov_short: cover property ($fell(conversion_busy_status) && busy_cnt_q == SHORT_CYC);
  cov_unmapped: cover property (psel && penable && pslverr);
endmodule // sarseq_props

bind sarseq_top sarseq_props #(.RES_W(RES_W), .SHORT_TRIALS(SHORT_TRIALS),
  .TRIAL_CYC(TRIAL_CYC)) u_props (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .paddr(paddr), .pslverr(pslverr),
  .capacitor_trial_dac(capacitor_trial_dac),
  .conversion_busy_status(conversion_busy_status), .data_out(data_out),
  .data_oe(data_oe));

// File: bench/sarseq_afe_model.sv
// Comparator of the analog front end that faces the sequencer.
// Assumes the trial code settles well within one pclk period.
`timescale 1ns/1ps
module sarseq_afe_model (
  input wire logic pclk,
  input wire logic [11:0] trial_code,
  input wire logic [11:0] vin_code,
  output logic comp_below
);
  // ====================================================
  // Comparator
  // The input sits half a step above vin_code, so an equal trial is below it.
  initial comp_below = 1'b0;
  always @(posedge pclk) begin
    comp_below <= (trial_code <= vin_code);
  end
endmodule // sarseq_afe_model

// File: bench/sar_conversion_sequencer_tb_top.sv
// Self-checking bench for the conversion sequencer top.
// Assumes the comparator model and the bound checker are compiled first.
`timescale 1ns/1ps
`include "sarseq_map.svh"
module sar_conversion_sequencer_tb_top;
  localparam int TC = 6;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr, busy, data_oe, irq, comp_below;
  logic start_pin = 1'b0;
  logic length_byte_select = 1'b0;
  logic read_cmd = 1'b0;
  logic [11:0] dac, data_out;
  logic [11:0] vin = 12'h000;
  int n_fail = 0;
  int n_checks = 0;
  always #12.5 pclk = ~pclk;
  sarseq_top #(.TRIAL_CYC(TC)) dut (.pclk(pclk), .presetn(presetn), .ce(1'b1),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .start_pin(start_pin),
    .length_byte_select(length_byte_select), .read_cmd_pin(read_cmd),
    .comp_below(comp_below), .capacitor_trial_dac(dac), .conversion_busy_status(busy),
    .data_out(data_out), .data_oe(data_oe), .irq(irq));
  sarseq_afe_model afe (.pclk(pclk), .trial_code(dac), .vin_code(vin),
    .comp_below(comp_below));
  // ====================================================
  // Shared tasks
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic stop_test();
    $display("checks=%0d mismatches=%0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] rd, output logic err);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // This wait ends at the first edge that samples pready high.
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] v;
    logic e;
    apb(1'b0, a, 32'h0, v, e);
    check(v, exp);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] v;
    logic e;
    apb(1'b1, a, d, v, e);
  endtask
  task automatic run_conv(input logic pin, input logic shrt, input logic [11:0] code,
                          input logic poke);
    realtime t0;
    int k;
    logic [11:0] exp;
    exp = shrt ? {code[11:4], 4'h8} : code;
    vin = code;
    @(posedge pclk);
    read_cmd <= 1'b1;
    length_byte_select <= shrt & pin;
    if (pin) begin
      @(posedge pclk);
      start_pin <= 1'b1;
    end else begin
      // The length goes in first, so the start strobe latches the new value.
      wr(`SARSEQ_OFF_CTRL, {30'h0, shrt, 1'b0});
      wr(`SARSEQ_OFF_CTRL, {30'h0, shrt, 1'b1});
    end
    // Always step to a falling edge first, so t0 never lands on the start edge.
    k = 0;
    do begin
      @(negedge pclk);
      k++;
    end while (busy !== 1'b1 && k < 50);
    t0 = $realtime;
    check({20'h0, dac}, 32'h800);
    if (poke) begin
      wr(`SARSEQ_OFF_CTRL, 32'h1);
      rd_chk(`SARSEQ_OFF_RESULT, 32'h0);
    end
    k = 0;
    while (busy === 1'b1 && k < 200) begin
      check({31'h0, data_oe}, 32'h0);
      @(negedge pclk);
      k++;
    end
    check(int'(($realtime - t0) / 25.0), (shrt ? 8 : 12) * TC);
    check({20'h0, data_out}, {20'h0, exp});
    start_pin <= 1'b0;
    rd_chk(`SARSEQ_OFF_RESULT, {20'h0, exp});
    rd_chk(`SARSEQ_OFF_STATUS, {29'h0, shrt, 2'b10});
    // The read command crosses a synchroniser before it can enable the outputs.
    repeat (3) @(posedge pclk);
    @(negedge pclk);
    check({31'h0, data_oe}, 32'h1);
    read_cmd <= 1'b0;
    repeat (3) @(posedge pclk);
    @(negedge pclk);
    check({31'h0, data_oe}, 32'h0);
  endtask
  // ====================================================
  // Scenarios
  task automatic scn_reset_regs();
    logic [31:0] v;
    logic e;
    rd_chk(`SARSEQ_OFF_CTRL, 32'h0);
    rd_chk(`SARSEQ_OFF_RESULT, 32'h0);
    rd_chk(`SARSEQ_OFF_INT_MASK, 32'h0);
    wr(`SARSEQ_OFF_STATUS, 32'h7);
    rd_chk(`SARSEQ_OFF_STATUS, 32'h0);
    apb(1'b0, 8'h40, 32'h0, v, e);
    check(v, 32'h0);
    check({31'h0, e}, 32'h1);
  endtask
  task automatic scn_codes();
    run_conv(1'b0, 1'b0, 12'hA5C, 1'b0);
    run_conv(1'b0, 1'b0, 12'h000, 1'b0);
    run_conv(1'b0, 1'b0, 12'hFFF, 1'b0);
    run_conv(1'b0, 1'b1, 12'hFFF, 1'b0);
  endtask
  task automatic scn_pin_lengths();
    run_conv(1'b1, 1'b1, 12'h3C7, 1'b0);
    run_conv(1'b1, 1'b0, 12'h9B1, 1'b0);
  endtask
  task automatic scn_busy_restart();
    wr(`SARSEQ_OFF_INT_MASK, 32'h0);
    rd_chk(`SARSEQ_OFF_INT_STAT, 32'h1);
    run_conv(1'b0, 1'b0, 12'h456, 1'b1);
    rd_chk(`SARSEQ_OFF_INT_STAT, 32'h3);
    rd_chk(`SARSEQ_OFF_INT_STAT, 32'h0);
  endtask
  task automatic scn_irq();
    run_conv(1'b0, 1'b0, 12'h123, 1'b0);
    check({31'h0, irq}, 32'h0);
    wr(`SARSEQ_OFF_INT_MASK, 32'h1);
    repeat (2) @(posedge pclk);
    @(negedge pclk);
    check({31'h0, irq}, 32'h1);
    rd_chk(`SARSEQ_OFF_INT_STAT, 32'h1);
    repeat (2) @(posedge pclk);
    @(negedge pclk);
    check({31'h0, irq}, 32'h0);
    rd_chk(`SARSEQ_OFF_INT_MASK, 32'h1);
  endtask
  // ====================================================
  // Main sequence and watchdog
  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    scn_reset_regs();
    scn_codes();
    scn_pin_lengths();
    scn_busy_restart();
    scn_irq();
    stop_test();
  end
  // The whole sequence needs well under 3000 cycles; this catches a hang.
  initial begin
    repeat (20000) @(posedge pclk);
    n_fail++;
    stop_test();
  end
endmodule // sar_conversion_sequencer_tb_top
